//--- design/fsw_link.sv
// serial clock side: command shifter, identifier and table output
`timescale 1ns/1ps
module fsw_link (
  input wire logic sclk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire fsw_pkg::fsw_gate_t gate_i,
  output fsw_pkg::fsw_frame_t frame_o,
  output logic so_o,
  output logic so_oe_o
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic [6:0] tbl_idx;
  fsw_pkg::fsw_gate_t g1_q;
  fsw_pkg::fsw_gate_t g2_q;
  fsw_pkg::fsw_frame_t frame_q;

  // wrap 63 back to 56 so the byte phase keeps running
  assign cnt_d = (cnt_q == 6'h3f) ? fsw_pkg::BITS_WRAP : cnt_q + 6'h01;
  assign tbl_idx = 7'h7f - {ptr_q[3:0], 3'h0};
  assign frame_o = frame_q;

  // bit counter, cleared while the frame is closed
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // permissions come from the other clock: two flops
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      g1_q <= '0;
      g2_q <= '0;
    end else begin
      g1_q <= gate_i;
      g2_q <= g1_q;
    end
  end

  // sample si on rising edges, msb first
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_q <= 8'h00;
      frame_q <= '0;
      ptr_q <= 8'h00;
    end else begin
      sh_q <= {sh_q[6:0], si_i};
      frame_q.bits <= cnt_d;
      if (cnt_q == 6'h00) begin
        frame_q.tgl <= ~frame_q.tgl;
      end
      if (cnt_q == 6'h07) begin
        frame_q.opc <= {sh_q[6:0], si_i};
      end
      if (cnt_q == 6'h1f) begin
        ptr_q <= {sh_q[6:0], si_i};
      end else if (cnt_q >= fsw_pkg::BITS_SFDP && cnt_q[2:0] == 3'h7) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // drive on falling edges; cs high ends the transfer
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (frame_q.opc == fsw_pkg::OP_WAKE_ID && cnt_q >= fsw_pkg::BITS_ID
                 && g2_q.id_ok) begin
      so_o <= fsw_pkg::DEV_ID[3'h7 - cnt_q[2:0]];
      so_oe_o <= 1'b1;
    end else if (frame_q.opc == fsw_pkg::OP_SFDP && cnt_q >= fsw_pkg::BITS_SFDP
                 && g2_q.sfdp_ok) begin
      // beyond the table the bytes read blank
      so_o <= (ptr_q < 8'h10) ? fsw_pkg::SFDP_TBL[tbl_idx - {4'h0, cnt_q[2:0]}]
                              : fsw_pkg::ERASED_BYTE[3'h7 - cnt_q[2:0]];
      so_oe_o <= 1'b1;
    end else begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end
  end
endmodule

//--- design/fsw_pkg.sv
// shared constants and types of the flash sleep and wake control block
package fsw_pkg;
  // command codes, eight bits, most significant bit first
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_SFDP = 8'h5a;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  // identifier byte; value is arbitrary
  localparam logic [7:0] DEV_ID = 8'h3c;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // status word layout and delivered value (quad enable set)
  localparam int STAT_WIP = 0;
  localparam int STAT_QE = 9;
  localparam int STAT_SUS = 15;
  localparam logic [15:0] STATUS_RST = 16'h0200;
  // bit counts inside a frame
  localparam logic [5:0] BITS_CMD = 6'h08;
  localparam logic [5:0] BITS_ID = 6'h20;
  localparam logic [5:0] BITS_SFDP = 6'h28;
  localparam logic [5:0] BITS_WRAP = 6'h38;
  // times and derived cycle counts at 40 MHz
  localparam int CLK_NS = 25;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_NS = 20000;
  localparam int WAKE_ID_NS = 20000;
  localparam int RESUME_WIP_NS = 200;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_ID_CYC = (WAKE_ID_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESUME_WIP_CYC = RESUME_WIP_NS / CLK_NS;
  // parameter table: signature, revision, one header, rest blank
  localparam logic [127:0] SFDP_TBL = 128'h53464450_060100ff_00060109_300000ff;
  typedef enum logic [1:0] {
    FSW_STBY = 2'b00,
    FSW_ENTER = 2'b01,
    FSW_SLEEP = 2'b10,
    FSW_WAKE = 2'b11
  } fsw_state_t;
  // frame snapshot handed from the serial clock side
  typedef struct packed {
    logic [7:0] opc;
    logic [5:0] bits;
    logic tgl;
  } fsw_frame_t;
  // output permissions handed to the serial clock side
  typedef struct packed {
    logic id_ok;
    logic sfdp_ok;
  } fsw_gate_t;
endpackage

//--- design/fsw_sleep_ctrl.sv
// flash resume, deep sleep, wake and identify command control
`timescale 1ns/1ps
// Notes on behaviour
// - resume is taken only with suspend set and write in progress clear
// - accepted resume clears suspend at once, sets busy within 200 ns
// - deep sleep is entered only by its command; writes are blocked there
// - in deep sleep only wake-and-identify and software reset are taken
// - chip select high with no internal cycle gives plain standby
// - deep sleep runs only if the frame held exactly eight bits
// - deep sleep is reached only after the sleep entry delay
// - deep sleep command during a running cycle is rejected
// - power loss clears deep sleep; power-up always gives standby
// - plain wake holds off all commands for the wake delay
// - identifier read: code, three dummy bytes, then id msb first
// - identifier repeats while clocked; chip select high ends it
// - wake with identifier holds off commands for its own delay
// - wake-and-identify during a running cycle is ignored
// - parameter read command returns the internal parameter table
// - delivered status reads zero except the quad enable bit nine
// - write in progress reads one for the whole self-timed cycle
// - accepted suspend sets suspend at once and clears busy soon
// - enable then reset frames clear sleep and suspend, restore defaults
module fsw_sleep_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic op_start_i,
  input wire logic op_done_i,
  input wire logic suspend_i,
  output logic so_o,
  output logic so_oe_o,
  output logic resume_o,
  output logic sw_reset_o,
  output logic deep_sleep_o,
  output logic standby_o,
  output logic cmd_ok_o,
  output logic write_block_o,
  output logic [15:0] status_o
);
  localparam int ResumeLast = fsw_pkg::RESUME_WIP_CYC - 1;
  localparam int DpCyc = fsw_pkg::SLEEP_ENTRY_CYC;

  fsw_pkg::fsw_frame_t frame;
  fsw_pkg::fsw_gate_t gate_q;
  fsw_pkg::fsw_state_t state_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic seen_q;
  logic frame_end;
  logic [9:0] tmr_q;
  logic sus_q;
  logic wip_q;
  logic rst_en_q;
  logic resume_q;
  logic sw_rst_q;
  logic resume_ok;
  logic dp_go;
  logic wake_go;
  logic rst_go;
  logic exact8;
  logic [15:0] status_w;
  logic [9:0] age_q;

  // true when a finished frame carried this command code
  function automatic logic cmd_is(input logic [7:0] code);
    cmd_is = frame_end && frame.opc == code && frame.bits >= fsw_pkg::BITS_CMD;
  endfunction

  fsw_link u_link (
    .sclk_i(sclk_i),
    .resetn_i(resetn_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .gate_i(gate_q),
    .frame_o(frame),
    .so_o(so_o),
    .so_oe_o(so_oe_o)
  );

  // pin into this clock through three flops, frame toggle through two
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tgl_s1_q <= frame.tgl;
      tgl_s2_q <= tgl_s1_q;
    end
  end

  // frame snapshot is quiet once chip select is seen high, since the
  // serial clock has stopped; the toggle tells a frame with no clocks
  assign frame_end = cs_s2_q && !cs_s3_q && (tgl_s2_q != seen_q);
  assign exact8 = frame.bits == fsw_pkg::BITS_CMD;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_q <= 1'b0;
    end else if (cs_s2_q && !cs_s3_q) begin
      seen_q <= tgl_s2_q;
    end
  end

  // command acceptance; a process, so what cmd_is reads wakes it too
  always_comb begin
    resume_ok = cmd_is(fsw_pkg::OP_RESUME) && sus_q && !wip_q
                && state_q == fsw_pkg::FSW_STBY;
    dp_go = cmd_is(fsw_pkg::OP_SLEEP) && exact8 && !wip_q
            && state_q == fsw_pkg::FSW_STBY;
    wake_go = cmd_is(fsw_pkg::OP_WAKE_ID) && !wip_q
              && state_q == fsw_pkg::FSW_SLEEP;
    // reset works in sleep too, but not while waking
    rst_go = cmd_is(fsw_pkg::OP_RST) && exact8 && rst_en_q
             && state_q != fsw_pkg::FSW_WAKE;
  end

  // reset enable lives for one following frame only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_en_q <= 1'b0;
    end else if (frame_end) begin
      rst_en_q <= cmd_is(fsw_pkg::OP_RST_EN) && exact8
                  && state_q != fsw_pkg::FSW_WAKE;
    end
  end

  // sleep state machine; reset leaves it in standby
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= fsw_pkg::FSW_STBY;
      tmr_q <= 10'h000;
    end else if (rst_go) begin
      state_q <= fsw_pkg::FSW_STBY;
      tmr_q <= 10'h000;
    end else begin
      unique case (state_q)
        fsw_pkg::FSW_STBY: begin
          if (dp_go) begin
            state_q <= fsw_pkg::FSW_ENTER;
            tmr_q <= 10'(DpCyc - 1);
          end
        end
        fsw_pkg::FSW_ENTER: begin
          if (tmr_q == 10'h000) begin
            state_q <= fsw_pkg::FSW_SLEEP;
          end else begin
            tmr_q <= tmr_q - 10'h001;
          end
        end
        fsw_pkg::FSW_SLEEP: begin
          // short frame is a plain wake, long one also read the id
          if (wake_go && exact8) begin
            state_q <= fsw_pkg::FSW_WAKE;
            tmr_q <= 10'(fsw_pkg::WAKE_CYC - 1);
          end else if (wake_go) begin
            state_q <= fsw_pkg::FSW_WAKE;
            tmr_q <= 10'(fsw_pkg::WAKE_ID_CYC - 1);
          end
        end
        fsw_pkg::FSW_WAKE: begin
          if (tmr_q == 10'h000) begin
            state_q <= fsw_pkg::FSW_STBY;
          end else begin
            tmr_q <= tmr_q - 10'h001;
          end
        end
      endcase
    end
  end

  // suspend flag: accepted suspend sets, accepted resume clears
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sus_q <= 1'b0;
    end else if (rst_go) begin
      sus_q <= 1'b0;
    end else if (suspend_i && wip_q && !sus_q) begin
      sus_q <= 1'b1;
    end else if (resume_ok) begin
      sus_q <= 1'b0;
    end
  end

  // busy flag: a start or resume set wins over a done or suspend clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wip_q <= 1'b0;
    end else if (rst_go) begin
      wip_q <= 1'b0;
    end else if (resume_q) begin
      wip_q <= 1'b1;
    end else if (op_start_i && !sus_q && state_q == fsw_pkg::FSW_STBY) begin
      wip_q <= 1'b1;
    end else if (op_done_i || (suspend_i && !sus_q)) begin
      wip_q <= 1'b0;
    end
  end

  // one-cycle pulses toward the command engine
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resume_q <= 1'b0;
      sw_rst_q <= 1'b0;
    end else begin
      resume_q <= resume_ok;
      sw_rst_q <= rst_go;
    end
  end

  // output permissions for the serial side, sampled there by two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_q <= '0;
    end else begin
      gate_q.id_ok <= !wip_q && (state_q == fsw_pkg::FSW_STBY
                                 || state_q == fsw_pkg::FSW_SLEEP);
      gate_q.sfdp_ok <= !wip_q && state_q == fsw_pkg::FSW_STBY;
    end
  end

  // status word: delivered value with live flags laid over it
  always_comb begin
    status_w = fsw_pkg::STATUS_RST;
    status_w[fsw_pkg::STAT_WIP] = wip_q;
    status_w[fsw_pkg::STAT_SUS] = sus_q;
  end

  assign status_o = status_w;
  assign resume_o = resume_q;
  assign sw_reset_o = sw_rst_q;
  assign deep_sleep_o = state_q == fsw_pkg::FSW_SLEEP;
  // standby is not sleep: deselected and idle
  assign standby_o = cs_s2_q && !wip_q && state_q == fsw_pkg::FSW_STBY;
  // engine may take other commands only in standby
  assign cmd_ok_o = state_q == fsw_pkg::FSW_STBY;
  // writes, programs and erases are refused outside standby
  assign write_block_o = state_q != fsw_pkg::FSW_STBY;

  // helper: cycles spent in sleep entry, read only by checks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      age_q <= 10'h000;
    end else if (state_q == fsw_pkg::FSW_ENTER) begin
      age_q <= age_q + 10'h001;
    end else begin
      age_q <= 10'h000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_resume_ok;
    resume_ok |=> !sus_q ##[0:ResumeLast] wip_q;
  endproperty
  a_resume_ok: assert property (p_resume_ok)
    else $error("resume did not clear suspend and set busy in time");

  property p_resume_ign;
    cmd_is(fsw_pkg::OP_RESUME) && !(sus_q && !wip_q) |=> !resume_q;
  endproperty
  a_resume_ign: assert property (p_resume_ign)
    else $error("resume taken in a wrong state");

  property p_enter_cause;
    $rose(state_q == fsw_pkg::FSW_ENTER) |-> $past(dp_go);
  endproperty
  a_enter_cause: assert property (p_enter_cause)
    else $error("sleep entry without its command");

  property p_entry_delay;
    $rose(deep_sleep_o) |-> $past(age_q) >= 10'(DpCyc - 1);
  endproperty
  a_entry_delay: assert property (p_entry_delay)
    else $error("deep sleep reached before entry delay");

  property p_dp_busy;
    cmd_is(fsw_pkg::OP_SLEEP) && wip_q && !op_done_i && !suspend_i
      |=> state_q == $past(state_q) && wip_q;
  endproperty
  a_dp_busy: assert property (p_dp_busy)
    else $error("sleep command disturbed running cycle");

  property p_dp_len;
    cmd_is(fsw_pkg::OP_SLEEP) && !exact8 |=> !$rose(state_q == fsw_pkg::FSW_ENTER);
  endproperty
  a_dp_len: assert property (p_dp_len)
    else $error("sleep command of wrong length executed");

  property p_sleep_filter;
    state_q == fsw_pkg::FSW_SLEEP && frame_end && frame.opc != fsw_pkg::OP_WAKE_ID
      && frame.opc != fsw_pkg::OP_RST |=> state_q == fsw_pkg::FSW_SLEEP;
  endproperty
  a_sleep_filter: assert property (p_sleep_filter)
    else $error("sleep left by a foreign command");

  property p_wake_hold;
    $rose(state_q == fsw_pkg::FSW_WAKE) |-> !cmd_ok_o [*8] ##1 !cmd_ok_o;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("commands allowed during wake delay");

  property p_wake_busy;
    cmd_is(fsw_pkg::OP_WAKE_ID) && wip_q |=> state_q == $past(state_q);
  endproperty
  a_wake_busy: assert property (p_wake_busy)
    else $error("wake command acted during busy cycle");

  property p_standby;
    deep_sleep_o || write_block_o |-> !standby_o;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby shown while asleep");

  property p_sw_reset;
    rst_go |=> state_q == fsw_pkg::FSW_STBY && !sus_q && !wip_q && sw_reset_o;
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset did not restore defaults");

  property p_suspend;
    suspend_i && wip_q && !sus_q && !rst_go |=> sus_q && !wip_q;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend flags wrong");

  property p_done;
    op_done_i && wip_q && !resume_q && !rst_go |=> !wip_q;
  endproperty
  a_done: assert property (p_done)
    else $error("busy not cleared at cycle end");

  property p_qe;
    status_o[fsw_pkg::STAT_QE] && status_o[8:1] == 8'h00;
  endproperty
  a_qe: assert property (p_qe)
    else $error("status word wrong");
endmodule

//--- sim/fsw_host_model.sv
// host side model: frames commands on chip select, clocks sclk, samples so
`timescale 1ns/1ps
module fsw_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  // link clock stands still low between frames; a clockless chip select
  // blip at start gives the link flops a defined clearing edge
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    #1 cs_n_o = 1'b1;
  end

  // low n bits of d go out msb first, then nrx bits are read back
  task automatic xfer(input logic [63:0] d, input int n, input int nrx,
                      output logic [31:0] rx);
    rx = 32'h0;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < n + nrx; i++) begin
      si_o = (i < n) ? d[n-1-i] : ~si_o;
      #40;
      // so moved on the falling edge, so it is settled here
      if (i >= n) begin
        rx = {rx[30:0], so_i};
      end
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    // released line must not keep showing the last bit
    si_o = ~si_o;
    #150;
  endtask
endmodule

//--- sim/fsw_sleep_ctrl_bench.sv
// self-checking bench for the sleep, wake and resume control block
`timescale 1ns/1ps
module fsw_sleep_ctrl_bench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic op_start_i = 1'b0;
  logic op_done_i = 1'b0;
  logic suspend_i = 1'b0;
  logic sclk_i, cs_n_i, si_i, so_o, so_oe_o, resume_o, sw_reset_o;
  logic deep_sleep_o, standby_o, cmd_ok_o, write_block_o;
  logic [15:0] status_o;
  logic [31:0] rx;
  int mismatches = 0;
  int n_tests = 0;
  int n_res = 0;
  int n_rst = 0;

  // core clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  fsw_host_model host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o));

  fsw_sleep_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .op_start_i(op_start_i), .op_done_i(op_done_i),
    .suspend_i(suspend_i), .so_o(so_o), .so_oe_o(so_oe_o), .resume_o(resume_o),
    .sw_reset_o(sw_reset_o), .deep_sleep_o(deep_sleep_o), .standby_o(standby_o),
    .cmd_ok_o(cmd_ok_o), .write_block_o(write_block_o), .status_o(status_o));

  // one-cycle pulses are counted in the cycle they stand
  always @(negedge clk_i) begin
    if (resume_o === 1'b1) n_res++;
    if (sw_reset_o === 1'b1) n_rst++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // inputs always move 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // first edge puts the pulse in the stimulus slot after a link call
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask

  // cs rise needs a few core edges to be decided
  task automatic send(input logic [63:0] d, input int n, input int nrx);
    host_u.xfer(d, n, nrx, rx);
    cyc(6);
  endtask

  task automatic cmd(input logic [7:0] op);
    send(64'(op), 8, 0);
  endtask

  function automatic logic [15:0] st(input logic w, input logic s);
    st = fsw_pkg::STATUS_RST;
    st[fsw_pkg::STAT_WIP] = w;
    st[fsw_pkg::STAT_SUS] = s;
  endfunction

  task automatic go_sleep();
    cmd(fsw_pkg::OP_SLEEP);
    cyc(130);
    chk(deep_sleep_o, 1'b1, "asleep");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic t_init();
    chk(status_o, st(0, 0), "delivered status");
    chk({deep_sleep_o, standby_o, cmd_ok_o, write_block_o}, 4'b0110, "idle");
    $display("test init done");
  endtask

  task automatic t_resume();
    cmd(fsw_pkg::OP_RESUME);
    chk(n_res, 0, "resume unsuspended");
    pulse(op_start_i);
    chk(status_o, st(1, 0), "busy on start");
    cmd(fsw_pkg::OP_RESUME);
    chk(n_res, 0, "resume while busy");
    pulse(suspend_i);
    chk(status_o, st(0, 1), "suspend taken");
    cmd(fsw_pkg::OP_RESUME);
    chk(n_res, 1, "resume taken");
    chk(status_o, st(1, 0), "resume flags");
    pulse(op_done_i);
    chk(status_o, st(0, 0), "cycle over");
    $display("test resume done");
  endtask

  task automatic t_sleep();
    pulse(op_start_i);
    cmd(fsw_pkg::OP_SLEEP);
    chk({deep_sleep_o, write_block_o}, 2'b00, "sleep while busy");
    chk(status_o, st(1, 0), "cycle kept");
    pulse(suspend_i);
    send(64'({fsw_pkg::OP_SLEEP, 1'b1}), 9, 0);
    chk(write_block_o, 1'b0, "nine bit sleep");
    cmd(fsw_pkg::OP_SLEEP);
    chk({deep_sleep_o, write_block_o, cmd_ok_o}, 3'b010, "entering");
    cyc(100);
    chk(deep_sleep_o, 1'b0, "entry delay");
    cyc(20);
    chk({deep_sleep_o, write_block_o}, 2'b11, "asleep, writes blocked");
    cmd(fsw_pkg::OP_RESUME);
    chk(n_res, 1, "resume in sleep");
    chk(status_o, st(0, 1), "flags in sleep");
    $display("test sleep done");
  endtask

  task automatic t_wake();
    cmd(fsw_pkg::OP_WAKE_ID);
    chk({deep_sleep_o, cmd_ok_o}, 2'b00, "waking");
    cmd(fsw_pkg::OP_SLEEP);
    cyc(690);
    chk(cmd_ok_o, 1'b0, "wake delay");
    // host keeps cs high through the rest of the wake delay
    cyc(80);
    chk({deep_sleep_o, cmd_ok_o, standby_o}, 3'b011, "awake");
    chk(status_o, st(0, 1), "poll before resume");
    cmd(fsw_pkg::OP_RESUME);
    chk(status_o, st(1, 0), "resumed");
    pulse(op_done_i);
    $display("test wake done");
  endtask

  task automatic t_ident();
    host_u.xfer(64'({fsw_pkg::OP_WAKE_ID, 24'h0}), 32, 16, rx);
    chk(rx[15:0], {2{fsw_pkg::DEV_ID}}, "id repeats");
    chk(so_oe_o, 1'b0, "so released");
    pulse(op_start_i);
    host_u.xfer(64'({fsw_pkg::OP_WAKE_ID, 24'h0}), 32, 8, rx);
    chk(rx[7:0], 8'h00, "id while busy");
    chk(status_o, st(1, 0), "cycle kept");
    pulse(op_done_i);
    go_sleep();
    host_u.xfer(64'({fsw_pkg::OP_WAKE_ID, 24'h0}), 32, 8, rx);
    cyc(6);
    chk({rx[7:0], deep_sleep_o, cmd_ok_o}, {fsw_pkg::DEV_ID, 2'b00}, "id wake");
    cyc(780);
    chk(cmd_ok_o, 1'b0, "id wake delay");
    cyc(20);
    chk(cmd_ok_o, 1'b1, "id wake over");
    $display("test ident done");
  endtask

  task automatic t_sfdp();
    host_u.xfer(64'({fsw_pkg::OP_SFDP, 32'h0}), 40, 32, rx);
    chk(rx, fsw_pkg::SFDP_TBL[127:96], "table head");
    host_u.xfer(64'({fsw_pkg::OP_SFDP, 24'h10, 8'h0}), 40, 8, rx);
    chk(rx[7:0], 8'hff, "past table");
    $display("test sfdp done");
  endtask

  task automatic t_swreset();
    pulse(op_start_i);
    pulse(suspend_i);
    go_sleep();
    cmd(fsw_pkg::OP_RST_EN);
    cmd(8'h05);
    cmd(fsw_pkg::OP_RST);
    chk(n_rst, 0, "broken pair");
    cmd(fsw_pkg::OP_RST_EN);
    cmd(fsw_pkg::OP_RST);
    chk(n_rst, 1, "reset taken");
    chk({deep_sleep_o, write_block_o}, 2'b00, "sleep cleared");
    chk(status_o, st(0, 0), "defaults back");
    $display("test swreset done");
  endtask

  // reset stands in for a power cycle in mid-sleep
  task automatic t_power();
    go_sleep();
    resetn_i = 1'b0;
    cyc(2);
    chk({deep_sleep_o, standby_o, cmd_ok_o}, 3'b011, "power-up state");
    chk(status_o, st(0, 0), "power-up status");
    resetn_i = 1'b1;
    cyc(2);
    $display("test power done");
  endtask

  initial begin
    cyc(20);
    resetn_i = 1'b1;
    cyc(2);
    t_init();
    t_resume();
    t_sleep();
    t_wake();
    t_ident();
    t_sfdp();
    t_swreset();
    t_power();
    wrap_up();
  end

  // the whole run needs about 100 us
  initial begin
    #400000;
    mismatches++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule
